// ### hdl/iobc_defs.svh
// Function
// - Pin control bit 7 set connects the auxiliary pin to the 5 V regulator.
// - Pin control bit 6 at 0 drives the open-drain pin low; 1 releases it.
// - Pin control bit 5 reads the sampled level of the general-purpose pin.
// - Pin control bit 2 set enters sleep; all protection comparators are disabled.
// - After sleep ends, voltage monitoring waits 1 ms for the reference to settle.
// - Pin control bits 1-0 connect each sensor return to converter ground.
// - Balance control bit n drives balance output n high; outputs default low.
// - Balance time register limits balance on-time from zero to 63 minutes.
// - A zero balance time limit keeps every balance output inactive.
// - Balance time bits 5-0 count seconds when bit 7 is 0, minutes when 1.
// - Writing 1 to trigger bit 0 starts a measurement; writing 0 starts nothing.
// - The start bit clears itself when the measurement begins and reads 0.
// - Each start measures the selected cells, temperatures and general input per setup.
`ifndef IOBC_DEFS_SVH
`define IOBC_DEFS_SVH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define IOBC_OFF_PIN_CONTROL 8'h31
`define IOBC_OFF_BAL_CONTROL 8'h32
`define IOBC_OFF_BAL_TIME 8'h33
`define IOBC_OFF_TRIGGER 8'h34

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define IOBC_PIN_AUX_BIT 7
`define IOBC_PIN_GPIO_OUT_BIT 6
`define IOBC_PIN_GPIO_IN_BIT 5
`define IOBC_PIN_SLEEP_BIT 2
`define IOBC_PIN_RETURN_MSB 1
`define IOBC_PIN_RETURN_LSB 0
`define IOBC_BAL_BITS_MSB 5
`define IOBC_TIME_UNIT_BIT 7
`define IOBC_TIME_FIELD_MSB 5
`define IOBC_TRIG_START_BIT 0
`define IOBC_SETUP_CELL_MSB 2
`define IOBC_SETUP_GPAI_BIT 3
`define IOBC_SETUP_TS_LSB 4
`define IOBC_SETUP_TS_MSB 5

// ----------------------------------------------------------------------
// Reset values and masks
// ----------------------------------------------------------------------
`define IOBC_PIN_CONTROL_RESET 8'h40
`define IOBC_PIN_CONTROL_WMASK 8'hc7
`define IOBC_BAL_CONTROL_RESET 8'h00
`define IOBC_BAL_CONTROL_WMASK 8'h3f
`define IOBC_BAL_TIME_RESET 8'h00
`define IOBC_BAL_TIME_WMASK 8'hbf
`define IOBC_READ_ZERO 8'h00

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define IOBC_CLK_MHZ 250
`define IOBC_SETTLE_TIME_US 1000
`define IOBC_SETTLE_CYCLES (`IOBC_SETTLE_TIME_US * `IOBC_CLK_MHZ)
`define IOBC_SECOND_TIME_US 1000000
`define IOBC_SECOND_CYCLES (`IOBC_SECOND_TIME_US * `IOBC_CLK_MHZ)
`define IOBC_MINUTE_LAST_SECOND 6'h3b

`endif

// ### hdl/iobc_pkg.sv
package iobc_pkg;

   typedef logic [7:0] iobc_byte_type;

   typedef enum logic [1:0] {
      IOBC_BAL_IDLE,
      IOBC_BAL_RUN,
      IOBC_BAL_EXPIRED
   } iobc_bal_state_type;

endpackage

// ### hdl/iobc_pin_sync.sv
`timescale 1ns/10ps

module iobc_pin_sync #(
   parameter logic RESET_LEVEL = 1'b1
) (
   // Clock and reset.
   input wire logic core_clk,
   input wire logic rst_n,
   // Asynchronous pin level and its filtered copy.
   input wire logic pin_in,
   output logic level
);

   logic stage1;
   logic stage2;
   logic stage3;

   // The level follows only once the second and third stages agree.
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         stage1 <= RESET_LEVEL;
         stage2 <= RESET_LEVEL;
         stage3 <= RESET_LEVEL;
         level <= RESET_LEVEL;
      end else begin
         stage1 <= pin_in;
         stage2 <= stage1;
         stage3 <= stage2;
         if (stage2 == stage3) begin
            level <= stage3;
         end
      end
   end

endmodule

// ### hdl/iobc_regs.sv
`timescale 1ns/10ps
`include "iobc_defs.svh"

module iobc_regs #(
   parameter int SETTLE_CYCLES = `IOBC_SETTLE_CYCLES,
   parameter int SECOND_CYCLES = `IOBC_SECOND_CYCLES
) (
   // Clock and reset.
   input wire logic core_clk,
   input wire logic rst_n,
   // Register port.
   input wire logic [7:0] reg_addr,
   input wire iobc_pkg::iobc_byte_type reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output iobc_pkg::iobc_byte_type reg_rdata,
   // Auxiliary supply switch.
   output logic five_volt_regulator_out,
   // Open-drain general-purpose pin.
   input wire logic gpio_i,
   output logic gpio_o,
   output logic gpio_oe_n,
   // Protection comparator enables.
   output logic undervoltage_comparator_en,
   output logic overvoltage_comparator_en,
   output logic overtemp_comparator_en,
   output logic sleep_mode,
   // Temperature sensor return switches.
   output logic [1:0] sensor_return_switch,
   // Cell balance outputs.
   output logic [5:0] balance_output,
   // Measurement unit.
   input wire iobc_pkg::iobc_byte_type measure_setup,
   output logic measure_start,
   output logic [2:0] measure_cells,
   output logic [1:0] measure_temp,
   output logic measure_gpai
);
   import iobc_pkg::*;

   // ----------------------------------------------------------------------
   // Address decode
   // ----------------------------------------------------------------------
   wire logic sel_pin = reg_addr == `IOBC_OFF_PIN_CONTROL;
   wire logic sel_bal = reg_addr == `IOBC_OFF_BAL_CONTROL;
   wire logic sel_time = reg_addr == `IOBC_OFF_BAL_TIME;
   wire logic sel_trig = reg_addr == `IOBC_OFF_TRIGGER;
   wire logic wr_pin = reg_wr && sel_pin;
   wire logic wr_bal = reg_wr && sel_bal;
   wire logic wr_time = reg_wr && sel_time;
   wire logic wr_trig = reg_wr && sel_trig;

   iobc_byte_type pin_control;
   iobc_byte_type balance_output_control;
   iobc_byte_type balance_time_limit;
   logic gpio_level;

   // ----------------------------------------------------------------------
   // Control registers
   // ----------------------------------------------------------------------
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         pin_control <= `IOBC_PIN_CONTROL_RESET;
         balance_output_control <= `IOBC_BAL_CONTROL_RESET;
         balance_time_limit <= `IOBC_BAL_TIME_RESET;
      end else begin
         if (wr_pin) begin
            pin_control <= reg_wdata & `IOBC_PIN_CONTROL_WMASK;
         end
         if (wr_bal) begin
            balance_output_control <= reg_wdata & `IOBC_BAL_CONTROL_WMASK;
         end
         if (wr_time) begin
            balance_time_limit <= reg_wdata & `IOBC_BAL_TIME_WMASK;
         end
      end
   end

   // ----------------------------------------------------------------------
   // Pin outputs
   // ----------------------------------------------------------------------
   wire logic sleep_req = pin_control[`IOBC_PIN_SLEEP_BIT];

   assign five_volt_regulator_out = pin_control[`IOBC_PIN_AUX_BIT];
   assign gpio_o = 1'b0;
   // The pin is driven low while the bit is 0 and released while it is 1.
   assign gpio_oe_n = pin_control[`IOBC_PIN_GPIO_OUT_BIT];
   assign sensor_return_switch = pin_control[`IOBC_PIN_RETURN_MSB:`IOBC_PIN_RETURN_LSB];
   assign sleep_mode = sleep_req;

   iobc_pin_sync #(
      .RESET_LEVEL(1'b1)
   ) u_gpio_sync (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .pin_in(gpio_i),
      .level(gpio_level)
   );

   // ----------------------------------------------------------------------
   // Sleep and reference settling
   // ----------------------------------------------------------------------
   logic [31:0] settle_count;
   logic monitor_ready;

   wire logic settle_done = settle_count == 32'(SETTLE_CYCLES - 1);

   // Voltage monitoring comes back only after the full settling wait.
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         settle_count <= 32'h0;
         monitor_ready <= 1'b0;
      end else if (sleep_req) begin
         settle_count <= 32'h0;
         monitor_ready <= 1'b0;
      end else if (!monitor_ready) begin
         settle_count <= settle_count + 32'h1;
         monitor_ready <= settle_done;
      end
   end

   assign undervoltage_comparator_en = monitor_ready && !sleep_req;
   assign overvoltage_comparator_en = monitor_ready && !sleep_req;
   assign overtemp_comparator_en = !sleep_req;

   // ----------------------------------------------------------------------
   // Balance timer
   // ----------------------------------------------------------------------
   iobc_bal_state_type bal_state;
   iobc_bal_state_type next_bal_state;
   logic [27:0] prescale;
   logic [5:0] minute_seconds;
   logic [5:0] unit_count;

   wire logic [5:0] limit_field = balance_time_limit[`IOBC_TIME_FIELD_MSB:0];
   wire logic unit_minutes = balance_time_limit[`IOBC_TIME_UNIT_BIT];
   wire logic bal_demand = (|balance_output_control) && (limit_field != 6'h0);
   wire logic bal_restart = wr_bal || wr_time;
   wire logic second_tick = prescale == 28'(SECOND_CYCLES - 1);
   wire logic minute_tick = second_tick && (minute_seconds == `IOBC_MINUTE_LAST_SECOND);
   wire logic unit_tick = unit_minutes ? minute_tick : second_tick;
   wire logic limit_hit = unit_tick && ((unit_count + 6'h1) == limit_field);
   wire logic count_clear = (bal_state != IOBC_BAL_RUN) || bal_restart;

   always_comb begin
      next_bal_state = bal_state;
      case (bal_state)
         IOBC_BAL_IDLE: begin
            if (bal_demand) begin
               next_bal_state = IOBC_BAL_RUN;
            end
         end
         IOBC_BAL_RUN: begin
            if (!bal_demand) begin
               next_bal_state = IOBC_BAL_IDLE;
            end else if (!bal_restart && limit_hit) begin
               next_bal_state = IOBC_BAL_EXPIRED;
            end
         end
         IOBC_BAL_EXPIRED: begin
            if (bal_restart) begin
               next_bal_state = IOBC_BAL_IDLE;
            end
         end
         default: begin
            next_bal_state = IOBC_BAL_IDLE;
         end
      endcase
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         bal_state <= IOBC_BAL_IDLE;
      end else begin
         bal_state <= next_bal_state;
      end
   end

   // A new command restarts the count from zero without dropping the outputs.
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         prescale <= 28'h0;
         minute_seconds <= 6'h0;
         unit_count <= 6'h0;
      end else if (count_clear) begin
         prescale <= 28'h0;
         minute_seconds <= 6'h0;
         unit_count <= 6'h0;
      end else begin
         prescale <= second_tick ? 28'h0 : prescale + 28'h1;
         if (second_tick) begin
            minute_seconds <= minute_tick ? 6'h0 : minute_seconds + 6'h1;
         end
         if (unit_tick) begin
            unit_count <= unit_count + 6'h1;
         end
      end
   end

   // Outputs stay off in the cycle that enters expiry or loads a zero limit.
   // Otherwise a stale pattern would show for one cycle.
   wire logic zero_limit_wr = wr_time && (reg_wdata[`IOBC_TIME_FIELD_MSB:0] == 6'h0);
   wire logic bal_allowed = bal_demand
                            && (bal_state != IOBC_BAL_EXPIRED)
                            && (next_bal_state != IOBC_BAL_EXPIRED)
                            && !zero_limit_wr;
   wire logic [5:0] next_balance = bal_allowed ? balance_output_control[`IOBC_BAL_BITS_MSB:0]
                                               : 6'h0;

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         balance_output <= 6'h0;
      end else begin
         balance_output <= next_balance;
      end
   end

   // ----------------------------------------------------------------------
   // Measurement start
   // ----------------------------------------------------------------------
   wire logic start_req = wr_trig && reg_wdata[`IOBC_TRIG_START_BIT];

   // The start bit is never stored, so it is gone as soon as the pulse is issued.
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         measure_start <= 1'b0;
         measure_cells <= 3'h0;
         measure_temp <= 2'h0;
         measure_gpai <= 1'b0;
      end else begin
         measure_start <= start_req;
         if (start_req) begin
            measure_cells <= measure_setup[`IOBC_SETUP_CELL_MSB:0];
            measure_temp <= measure_setup[`IOBC_SETUP_TS_MSB:`IOBC_SETUP_TS_LSB];
            measure_gpai <= measure_setup[`IOBC_SETUP_GPAI_BIT];
         end
      end
   end

   // ----------------------------------------------------------------------
   // Read back
   // ----------------------------------------------------------------------
   iobc_byte_type pin_readback;
   iobc_byte_type next_rdata;

   always_comb begin
      pin_readback = pin_control;
      pin_readback[`IOBC_PIN_GPIO_IN_BIT] = gpio_level;
   end

   // The trigger register and unmapped offsets read as zero.
   assign next_rdata = sel_pin ? pin_readback :
                       sel_bal ? balance_output_control :
                       sel_time ? balance_time_limit :
                       `IOBC_READ_ZERO;

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         reg_rdata <= `IOBC_READ_ZERO;
      end else if (reg_rd) begin
         reg_rdata <= next_rdata;
      end
   end

endmodule

// ### verification/iobc_regs_asserts.sv
`timescale 1ns/10ps

module iobc_regs_asserts #(
   parameter int SETTLE_CYCLES = 20,
   parameter int SECOND_CYCLES = 10
) (
   // Clock and reset.
   input wire logic core_clk,
   input wire logic rst_n,
   // Register port.
   input wire logic [7:0] reg_addr,
   input wire iobc_pkg::iobc_byte_type reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire iobc_pkg::iobc_byte_type reg_rdata,
   // Pins and comparator enables.
   input wire logic five_volt_regulator_out,
   input wire logic gpio_o,
   input wire logic gpio_oe_n,
   input wire logic undervoltage_comparator_en,
   input wire logic overvoltage_comparator_en,
   input wire logic overtemp_comparator_en,
   input wire logic sleep_mode,
   input wire logic [1:0] sensor_return_switch,
   input wire logic [5:0] balance_output,
   // Measurement unit.
   input wire iobc_pkg::iobc_byte_type measure_setup,
   input wire logic measure_start,
   input wire logic [2:0] measure_cells
);
   import iobc_pkg::*;
   wire logic pin_wr = reg_wr && reg_addr == 8'h31;
   wire logic go_wr = reg_wr && reg_addr == 8'h34 && reg_wdata[0];
   wire logic zero_wr = reg_wr && reg_addr == 8'h33 && reg_wdata[5:0] == 6'h00;
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   a_aux_switch: assert property (
      pin_wr |=> five_volt_regulator_out == $past(reg_wdata[7]))
      else $error("aux switch mismatch");
   a_gpio_drive: assert property (
      pin_wr |=> gpio_oe_n == $past(reg_wdata[6]) && !gpio_o)
      else $error("gpio drive mismatch");
   a_sleep_off: assert property (
      sleep_mode |-> !undervoltage_comparator_en && !overvoltage_comparator_en
         && !overtemp_comparator_en)
      else $error("comparator on in sleep");
   a_settle_wait: assert property (
      $fell(sleep_mode) |-> (!undervoltage_comparator_en && !overvoltage_comparator_en)[*8])
      else $error("monitor back too early");
   a_return_sw: assert property (
      pin_wr |=> sensor_return_switch == $past(reg_wdata[1:0]))
      else $error("return switch mismatch");
   a_zero_limit: assert property (
      zero_wr |=> balance_output == 6'h00)
      else $error("balance on with zero limit");
   a_start_pulse: assert property (
      go_wr |=> measure_start && measure_cells == $past(measure_setup[2:0]))
      else $error("start pulse mismatch");
   a_start_cause: assert property (
      measure_start |-> $past(go_wr))
      else $error("start without request");
   a_trig_read: assert property (
      reg_rd && reg_addr == 8'h34 |=> reg_rdata == 8'h00)
      else $error("trigger read not zero");
endmodule

bind iobc_regs iobc_regs_asserts #(.SETTLE_CYCLES(SETTLE_CYCLES), .SECOND_CYCLES(SECOND_CYCLES))
   i_iobc_regs_asserts (.core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr),
   .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
   .five_volt_regulator_out(five_volt_regulator_out), .gpio_o(gpio_o), .gpio_oe_n(gpio_oe_n),
   .undervoltage_comparator_en(undervoltage_comparator_en),
   .overvoltage_comparator_en(overvoltage_comparator_en),
   .overtemp_comparator_en(overtemp_comparator_en), .sleep_mode(sleep_mode),
   .sensor_return_switch(sensor_return_switch), .balance_output(balance_output),
   .measure_setup(measure_setup), .measure_start(measure_start),
   .measure_cells(measure_cells));

// ### verification/io_balance_convert_regs_tb.sv
`timescale 1ns/10ps

module io_balance_convert_regs_tb;
   import iobc_pkg::*;
   localparam int SETTLE = 20;
   logic core_clk = 1'b0;
   logic rst_n = 1'b0;
   logic [7:0] reg_addr = 8'h00;
   iobc_byte_type reg_wdata = 8'h00;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   iobc_byte_type measure_setup = 8'h00;
   logic ext_low = 1'b0;
   iobc_byte_type reg_rdata;
   logic five_volt_regulator_out, gpio_o, gpio_oe_n, sleep_mode, measure_start, measure_gpai;
   logic undervoltage_comparator_en, overvoltage_comparator_en, overtemp_comparator_en;
   logic [1:0] sensor_return_switch, measure_temp;
   logic [5:0] balance_output;
   logic [2:0] measure_cells;
   int fails = 0;
   int check_count = 0;
   int cycles = 0;
   // The pin is pulled up; it is low when either side pulls it down.
   wire logic gpio_i = gpio_oe_n ? !ext_low : gpio_o;

   iobc_regs #(.SETTLE_CYCLES(SETTLE), .SECOND_CYCLES(10)) i_iobc_regs (.core_clk(core_clk),
      .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .five_volt_regulator_out(five_volt_regulator_out),
      .gpio_i(gpio_i), .gpio_o(gpio_o), .gpio_oe_n(gpio_oe_n),
      .undervoltage_comparator_en(undervoltage_comparator_en),
      .overvoltage_comparator_en(overvoltage_comparator_en),
      .overtemp_comparator_en(overtemp_comparator_en), .sleep_mode(sleep_mode),
      .sensor_return_switch(sensor_return_switch), .balance_output(balance_output),
      .measure_setup(measure_setup), .measure_start(measure_start),
      .measure_cells(measure_cells), .measure_temp(measure_temp), .measure_gpai(measure_gpai));

   // ------
   // Shared tasks
   // ------
   task check(input logic [7:0] seen, input logic [7:0] exp);
      check_count++;
      if (seen !== exp) begin
         fails++;
         $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   // An idle cycle after each strobe keeps two transfers from sharing a time step.
   task wr(input logic [7:0] a, input logic [7:0] d);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(negedge core_clk);
      reg_wr = 1'b0;
      @(negedge core_clk);
   endtask
   task rd(input logic [7:0] a, input logic [7:0] exp);
      reg_addr = a;
      reg_rd = 1'b1;
      @(negedge core_clk);
      reg_rd = 1'b0;
      @(negedge core_clk);
      check(reg_rdata, exp);
   endtask
   task tick(input int n);
      repeat (n) @(negedge core_clk);
   endtask
   task stop_test;
      $display("checks %0d mismatches %0d", check_count, fails);
      if (fails == 0 && check_count > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   // ------
   // Scenarios
   // ------
   task t_reset;
      check(8'(undervoltage_comparator_en), 8'h00);
      check(8'({five_volt_regulator_out, gpio_oe_n}), 8'h01);
      check(8'(balance_output), 8'h00);
      rd(8'h32, 8'h00);
      rd(8'h33, 8'h00);
      rd(8'h34, 8'h00);
      rd(8'h35, 8'h00);
      rd(8'h31, 8'h60);
   endtask
   task t_pin;
      wr(8'h31, 8'hff);
      check(8'({five_volt_regulator_out, sleep_mode, sensor_return_switch}), 8'h0f);
      check(8'({undervoltage_comparator_en, overvoltage_comparator_en, overtemp_comparator_en}),
         8'h00);
      tick(6);
      rd(8'h31, 8'he7);
      wr(8'h31, 8'h00);
      check(8'({gpio_oe_n, gpio_o, sensor_return_switch}), 8'h00);
      tick(6);
      rd(8'h31, 8'h00);
      wr(8'h31, 8'h40);
      ext_low = 1'b1;
      tick(6);
      rd(8'h31, 8'h40);
      ext_low = 1'b0;
      tick(6);
      rd(8'h31, 8'h60);
   endtask
   task t_settle;
      int n;
      wr(8'h31, 8'h44);
      check(8'({undervoltage_comparator_en, overtemp_comparator_en}), 8'h00);
      tick(3);
      wr(8'h31, 8'h40);
      check(8'(overtemp_comparator_en), 8'h01);
      n = 0;
      while (undervoltage_comparator_en !== 1'b1 && n < 100) begin
         @(negedge core_clk);
         n++;
      end
      check(8'(n >= SETTLE - 2 && n <= SETTLE + 2), 8'h01);
      check(8'(overvoltage_comparator_en), 8'h01);
   endtask
   task t_balance;
      wr(8'h33, 8'hff);
      rd(8'h33, 8'hbf);
      wr(8'h33, 8'h02);
      wr(8'h32, 8'hff);
      check(8'(balance_output), 8'h3f);
      rd(8'h32, 8'h3f);
      tick(13);
      check(8'(balance_output), 8'h3f);
      tick(14);
      check(8'(balance_output), 8'h00);
      rd(8'h32, 8'h3f);
      wr(8'h32, 8'h15);
      check(8'(balance_output), 8'h15);
      wr(8'h33, 8'h81);
      tick(500);
      check(8'(balance_output), 8'h15);
      tick(150);
      check(8'(balance_output), 8'h00);
      wr(8'h33, 8'h00);
      wr(8'h32, 8'h3f);
      check(8'(balance_output), 8'h00);
   endtask
   task t_start;
      measure_setup = 8'h3d;
      wr(8'h34, 8'h00);
      check(8'(measure_start), 8'h00);
      reg_addr = 8'h34;
      reg_wdata = 8'h01;
      reg_wr = 1'b1;
      @(negedge core_clk);
      check(8'({measure_start, measure_cells, measure_temp, measure_gpai}), 8'h6f);
      measure_setup = 8'h02;
      @(negedge core_clk);
      check(8'(measure_start), 8'h01);
      reg_wr = 1'b0;
      check(8'({measure_start, measure_cells}), 8'h0a);
      @(negedge core_clk);
      check(8'(measure_start), 8'h00);
      rd(8'h34, 8'h00);
   endtask

   initial begin
      forever #2 core_clk = ~core_clk;
   end
   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 5000) begin
         fails++;
         stop_test();
      end
   end
   initial begin
      repeat (6) @(negedge core_clk);
      rst_n = 1'b1;
      t_reset();
      t_pin();
      t_settle();
      t_balance();
      t_start();
      stop_test();
   end
endmodule
